// ===== hw/mft_pkg.sv
// Notes on behaviour
// - each timer has 8-bit status/enable and config registers, status bits 7..0 fixed
// - capture/compare mode: capture edge on input a or b sets its sticky flag
// - capture irq enable set: valid capture edge raises the timer interrupt request
// - compare flag b sets on counter equal register b, only when b compares
// - compare flag a sets when counter equals compare register a, only when a compares; sticky
// - compare irq enable set: match against either compare register raises request
// - wrap flag sets when counter counts on from FFFF to 0000, not on a clear at match; sticky
// - wrap irq enable set: each counter wrap raises the interrupt request
// - timer1 config bit 7 is sticky, set when real-time counter wraps FF to 00
// - capture edge select: 1 rising edges, 0 falling edges, both capture inputs
// - external clock edge select: 1 rising edges count, 0 falling edges count
// - prescaler field bits 4..2 divides system clock by 2 to the code
// - mode field bits 1..0: 00 soft, 01 pwm, 10 capture/compare, 11 events
// - timer2 config bit 7 selects port read source: 0 pins, 1 output register
// - pwm: count to a, clear, toggle, then to b, clear, toggle, alternating
// - software mode works like pwm without toggling; overflow also interrupts
// - capture/compare: counter free-runs; capture edge stores count; b is capture b
// - capture/compare: match on a toggles output, counter keeps counting
package mft_pkg;

  // register byte offsets inside one timer's window, window stride 0x20
  localparam logic [4:0] OFS_STAT = 5'h00;
  localparam logic [4:0] OFS_CFG  = 5'h04;
  localparam logic [4:0] OFS_CMPA = 5'h08;
  localparam logic [4:0] OFS_CMPB = 5'h0C;
  localparam logic [4:0] OFS_CAPA = 5'h10;
  localparam logic [4:0] OFS_CNT  = 5'h14;
  localparam int unsigned TSEL_BIT = 5;

  // status / enable register fields
  localparam int unsigned ST_CAPB   = 7;
  localparam int unsigned ST_CAPA   = 6;
  localparam int unsigned ST_CAPIE  = 5;
  localparam int unsigned ST_CMPB   = 4;
  localparam int unsigned ST_CMPA   = 3;
  localparam int unsigned ST_CMPIE  = 2;
  localparam int unsigned ST_WRAP   = 1;
  localparam int unsigned ST_WRAPIE = 0;
  localparam logic [7:0]  ST_FLAGS  = 8'hDA;

  // config register fields
  localparam int unsigned CF_TOP     = 7;
  localparam int unsigned CF_CAPEDGE = 6;
  localparam int unsigned CF_EXTEDGE = 5;
  localparam int unsigned CF_PS_LSB  = 2;
  localparam int unsigned CF_MODE_LSB = 0;

  // reset values and counter limits
  localparam logic [7:0]  STAT_RST = 8'h00;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [6:0]  PS_RST   = 7'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_SOFT   = 2'h0,
    MODE_PWM    = 2'h1,
    MODE_CAPCMP = 2'h2,
    MODE_EXTCNT = 2'h3
  } mft_mode_e;

  typedef enum logic {
    PH_A = 1'b0,
    PH_B = 1'b1
  } mft_phase_e;

  // pin group of one timer, also used for the detected edge pulses
  typedef struct packed {
    logic capA;
    logic capB;
    logic extClk;
  } mft_pins_s;

  // bus request held over into the data phase
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       hit;
    logic       tsel;
    logic [4:0] ofs;
  } mft_req_s;

endpackage

// ===== hw/mft_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mft_edge_sync
  import mft_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  input  wire mft_pins_s pinsIn,
  input  wire logic      capEdgeSel,
  input  wire logic      extEdgeSel,
  output mft_pins_s      edgeOut
);

  mft_pins_s syncA_reg;
  mft_pins_s syncB_reg;
  mft_pins_s hist_reg;
  mft_pins_s rise;
  mft_pins_s fall;

  // two stages for the asynchronous pins, then one stage of history
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      hist_reg  <= '0;
    end else begin
      syncA_reg <= pinsIn;
      syncB_reg <= syncA_reg;
      hist_reg  <= syncB_reg;
    end
  end

  assign rise = syncB_reg & ~hist_reg;
  assign fall = ~syncB_reg & hist_reg;

  // edge polarity chosen per input class
  assign edgeOut.capA   = capEdgeSel ? rise.capA : fall.capA;
  assign edgeOut.capB   = capEdgeSel ? rise.capB : fall.capB;
  assign edgeOut.extClk = extEdgeSel ? rise.extClk : fall.extClk;

endmodule
`default_nettype wire

// ===== hw/mft_timer_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module mft_timer_ctrl
  import mft_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic [31:0]          hrdata,
  output logic                 hresp,
  // timer pins and system events
  input  wire mft_pins_s [1:0] timerPins,
  input  wire logic            rtWrap,
  output logic [1:0]           timerOut,
  output logic [1:0]           timerIrq,
  output logic                 portReadSrc
);

  mft_req_s    req_reg;
  logic        accept;
  logic [31:0] rdVal [2];
  logic [7:0]  cfgTop [2];

  // only word transfers are expected; narrower sizes act as whole words
  assign accept = hsel && hready && htrans[1];

  // address phase capture; reads take one wait state so that they see the
  // registers after any write whose data phase ended at the same edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_reg   <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      req_reg.wr   <= accept && hwrite;
      req_reg.rd   <= accept && !hwrite;
      req_reg.hit  <= (haddr[31:6] == 26'h0) && (hsize <= 3'h2);
      req_reg.tsel <= haddr[TSEL_BIT];
      req_reg.ofs  <= {haddr[4:2], 2'b00};
      hreadyout    <= !(accept && !hwrite);
      hresp        <= 1'b0;
    end
  end

  // read data launched in the wait cycle; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= RDATA_RST;
    end else if (req_reg.rd) begin
      hrdata <= req_reg.hit ? rdVal[req_reg.tsel] : RDATA_RST;
    end
  end

  // port read source sits in timer2's config top bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      portReadSrc <= 1'b0;
    end else begin
      portReadSrc <= cfgTop[1][CF_TOP];
    end
  end

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_tmr
      logic [7:0]  stat_reg;
      logic [7:0]  stat_next;
      logic [7:0]  cfg_reg;
      logic [7:0]  cfg_next;
      logic [15:0] cmpA_reg;
      logic [15:0] cmpB_reg;
      logic [15:0] capA_reg;
      logic [15:0] cnt_reg;
      logic [6:0]  ps_reg;
      mft_phase_e  phase_reg;
      logic        out_reg;
      logic        irq_reg;
      mft_pins_s   edges;
      mft_mode_e   mode;
      logic [2:0]  psSel;
      logic [6:0]  psMask;
      logic        psTick;
      logic        tick;
      logic        isCapCmp;
      logic [15:0] target;
      logic        match;
      logic        setCmpA;
      logic        setCmpB;
      logic        setWrap;
      logic        setCapA;
      logic        setCapB;
      logic        selThis;
      logic        wrStat;
      logic        wrCfg;
      logic        wrCmpA;
      logic        wrCmpB;

      mft_edge_sync u_sync (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .pinsIn     (timerPins[t]),
        .capEdgeSel (cfg_reg[CF_CAPEDGE]),
        .extEdgeSel (cfg_reg[CF_EXTEDGE]),
        .edgeOut    (edges)
      );

      // write strobes for this timer's window, taken in the data phase
      assign selThis = req_reg.wr && req_reg.hit && (req_reg.tsel == 1'(t));
      assign wrStat  = selThis && (req_reg.ofs == OFS_STAT);
      assign wrCfg   = selThis && (req_reg.ofs == OFS_CFG);
      assign wrCmpA  = selThis && (req_reg.ofs == OFS_CMPA);
      assign wrCmpB  = selThis && (req_reg.ofs == OFS_CMPB);

      // mode and prescaler decode
      assign mode     = mft_mode_e'(cfg_reg[CF_MODE_LSB +: 2]);
      assign psSel    = cfg_reg[CF_PS_LSB +: 3];
      assign psMask   = 7'((8'h01 << psSel) - 8'h01);
      assign psTick   = (ps_reg & psMask) == psMask;
      assign isCapCmp = (mode == MODE_CAPCMP);
      // external event mode counts pin edges instead of prescaled clocks
      assign tick     = (mode == MODE_EXTCNT) ? edges.extClk : psTick;

      // in capture/compare only register a compares; otherwise phase picks it
      assign target = (isCapCmp || phase_reg == PH_A) ? cmpA_reg : cmpB_reg;
      assign match  = tick && (cnt_reg == target);
      assign setCmpA = match && (isCapCmp || phase_reg == PH_A);
      assign setCmpB = match && !isCapCmp && phase_reg == PH_B;
      // a clear on match is no wrap; the free-running count wraps in any mode
      assign setWrap = tick && (cnt_reg == CNT_MAX) && (isCapCmp || !match);
      assign setCapA = isCapCmp && edges.capA;
      assign setCapB = isCapCmp && edges.capB;

      // prescaler runs freely so a divisor change takes effect at once
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          ps_reg <= PS_RST;
        end else begin
          ps_reg <= ps_reg + 7'h01;
        end
      end

      // 16-bit counter: cleared on match except in capture/compare
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          cnt_reg <= CNT_RST;
        end else if (tick) begin
          if (match && !isCapCmp) begin
            cnt_reg <= CNT_RST;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end

      // phase alternates between the two compare registers
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          phase_reg <= PH_A;
        end else if (isCapCmp) begin
          phase_reg <= PH_A;
        end else if (match) begin
          phase_reg <= (phase_reg == PH_A) ? PH_B : PH_A;
        end
      end

      // output toggle: pwm and event counter on every match, capture/compare
      // on a only; software timer leaves the pin alone
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          out_reg <= 1'b0;
        end else if (match && mode != MODE_SOFT) begin
          out_reg <= !out_reg;
        end
      end
      // software mode toggles nothing, it only raises flags and requests

      // compare register a is software only
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          cmpA_reg <= CNT_RST;
        end else if (wrCmpA) begin
          cmpA_reg <= hwdata[15:0];
        end
      end

      // register b doubles as capture b; a capture beats a software write
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          cmpB_reg <= CNT_RST;
        end else if (setCapB) begin
          cmpB_reg <= cnt_reg;
        end else if (wrCmpB) begin
          cmpB_reg <= hwdata[15:0];
        end
      end

      // dedicated capture register a
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          capA_reg <= CNT_RST;
        end else if (setCapA) begin
          capA_reg <= cnt_reg;
        end
      end

      // status: enables written directly, flags only cleared by a written 0,
      // hardware sets applied last so they win over a clear
      always_comb begin
        stat_next = stat_reg;
        if (wrStat) begin
          stat_next = (hwdata[7:0] & ~ST_FLAGS) |
                      (stat_reg & hwdata[7:0] & ST_FLAGS);
        end
        if (setCapB) stat_next[ST_CAPB] = 1'b1;
        if (setCapA) stat_next[ST_CAPA] = 1'b1;
        if (setCmpB) stat_next[ST_CMPB] = 1'b1;
        if (setCmpA) stat_next[ST_CMPA] = 1'b1;
        if (setWrap) stat_next[ST_WRAP] = 1'b1;
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          stat_reg <= STAT_RST;
        end else begin
          stat_reg <= stat_next;
        end
      end

      // config: timer1's top bit is the sticky real-time wrap flag,
      // timer2's top bit is a plain control bit
      always_comb begin
        cfg_next = cfg_reg;
        if (wrCfg) begin
          cfg_next = hwdata[7:0];
          if (t == 0) begin
            cfg_next[CF_TOP] = cfg_reg[CF_TOP] & hwdata[CF_TOP];
          end
        end
        if (t == 0 && rtWrap) begin
          cfg_next[CF_TOP] = 1'b1;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          cfg_reg <= CFG_RST;
        end else begin
          cfg_reg <= cfg_next;
        end
      end

      // request held as long as any enabled flag stays set
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          irq_reg <= 1'b0;
        end else begin
          irq_reg <= (stat_reg[ST_CAPIE] && (stat_reg[ST_CAPA] || stat_reg[ST_CAPB])) ||
                     (stat_reg[ST_CMPIE] && (stat_reg[ST_CMPA] || stat_reg[ST_CMPB])) ||
                     (stat_reg[ST_WRAPIE] && stat_reg[ST_WRAP]);
        end
      end

      // register read view of this timer
      always_comb begin
        rdVal[t] = RDATA_RST;
        unique case (req_reg.ofs)
          OFS_STAT: rdVal[t] = {24'h0, stat_reg};
          OFS_CFG:  rdVal[t] = {24'h0, cfg_reg};
          OFS_CMPA: rdVal[t] = {16'h0, cmpA_reg};
          OFS_CMPB: rdVal[t] = {16'h0, cmpB_reg};
          OFS_CAPA: rdVal[t] = {16'h0, capA_reg};
          OFS_CNT:  rdVal[t] = {16'h0, cnt_reg};
          default:  rdVal[t] = RDATA_RST;
        endcase
      end

      assign cfgTop[t]   = cfg_reg;
      assign timerOut[t] = out_reg;
      assign timerIrq[t] = irq_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== test/mft_timer_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mft_timer_ctrl_asserts
  import mft_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic [31:0]     hrdata,
  input wire logic            hresp,
  input wire mft_pins_s [1:0] timerPins,
  input wire logic            rtWrap,
  input wire logic [1:0]      timerOut,
  input wire logic [1:0]      timerIrq,
  input wire logic            portReadSrc
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic            taken;
  logic            hit;
  logic            wrQ;
  logic            rdUnmQ;
  logic [5:0]      adrQ;
  logic [1:0][1:0] modeQ;
  logic [1:0]      enQ;
  logic            cfgWr2;
  // decode of a taken address phase
  assign taken = hsel && hready && htrans[1];
  assign hit = (haddr[31:6] == 26'h0) && (haddr[4:2] < 3'h6) && (hsize <= 3'h2);
  assign cfgWr2 = wrQ && (adrQ == 6'h24);
  // address phase held over to the data phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrQ <= 1'b0;
      rdUnmQ <= 1'b0;
      adrQ <= 6'h00;
    end else begin
      wrQ <= taken && hwrite && hit;
      rdUnmQ <= taken && !hwrite && !hit;
      if (taken) adrQ <= haddr[5:0];
    end
  end
  // shadow of modes and enables, so checks need no access to internals
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      modeQ <= '0;
      enQ <= 2'h0;
    end else if (wrQ && adrQ[4:0] == OFS_CFG) begin
      modeQ[adrQ[5]] <= hwdata[1:0];
    end else if (wrQ && adrQ[4:0] == OFS_STAT) begin
      enQ[adrQ[5]] <= |(hwdata[7:0] & 8'h25);
    end
  end
  AST_READ_WAIT: assert property (taken && !hwrite && hit |=> !hreadyout)
    else $error("read without wait state");
  AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_UNMAPPED_ZERO: assert property (rdUnmQ |-> ##[0:1] (hreadyout && hrdata == 32'h0))
    else $error("unmapped read not zero");
  AST_PORTSRC: assert property ($changed(portReadSrc) |-> $past(cfgWr2) || $past(cfgWr2, 2) || $past(cfgWr2, 3))
    else $error("port read source changed on its own");
  // one set per timer
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic stWr;
    assign stWr = wrQ && (adrQ[5] == t) && (adrQ[4:0] == OFS_STAT);
    AST_IRQ_RISE: assert property ($rose(timerIrq[t]) |-> enQ[t])
      else $error("request without enable");
    AST_IRQ_FALL: assert property ($fell(timerIrq[t]) |-> $past(stWr) || $past(stWr, 2))
      else $error("request dropped without status write");
    AST_SOFT_STILL: assert property ((modeQ[t] == MODE_SOFT) [*3] |=> $stable(timerOut[t]))
      else $error("output toggled in software mode");
  end
endmodule
bind mft_timer_ctrl mft_timer_ctrl_asserts u_mft_timer_ctrl_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timerPins(timerPins),
  .rtWrap(rtWrap), .timerOut(timerOut), .timerIrq(timerIrq), .portReadSrc(portReadSrc)
);
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import mft_pkg::*;
;
  logic            ref_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            hsel = 1'b0;
  logic [31:0]     haddr = 32'h0;
  logic [1:0]      htrans = 2'h0;
  logic            hwrite = 1'b0;
  logic [2:0]      hsize = 3'h2;
  logic [31:0]     hwdata = 32'h0;
  logic            hready;
  logic [31:0]     hrdata;
  logic            hresp;
  mft_pins_s [1:0] pins = '0;
  logic            rtWrap = 1'b0;
  logic [1:0]      timerOut;
  logic [1:0]      timerIrq;
  logic            portReadSrc;
  int              failures = 0;
  int              n_tests = 0;
  logic [31:0]     rd;
  int              i1;
  int              i2;
  int              eA;
  int              eB;
  logic            prev;
  // 10 MHz system clock
  always #50 ref_clk = ~ref_clk;
  mft_timer_ctrl u_mft_timer_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .timerPins(pins),
    .rtWrap(rtWrap), .timerOut(timerOut), .timerIrq(timerIrq), .portReadSrc(portReadSrc)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer; waits on hready only, the watchdog bounds it
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic tog(input int t, output int n);
    logic v;
    v = timerOut[t];
    n = 0;
    while (timerOut[t] === v && n < 70000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(87));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    // zero compare registers match at once, so both compare flags show
    for (int a = 0; a < 17; a++) rchk(a * 4, (a == 0 || a == 8) ? 32'h18 : 32'h0);
    chk({hresp, portReadSrc, timerIrq}, 4'h0);
    hsize <= 3'h3;
    bus(32'h08, 1'b1, 32'h77);
    hsize <= 3'h2;
    rchk(32'h08, 32'h0);
    eA = $urandom_range(6, 2);
    eB = $urandom_range(6, 2);
    bus(32'h0C, 1'b1, eB);
    bus(32'h08, 1'b1, eA);
    // pwm half periods for every prescaler code
    for (int p = 0; p < 8; p++) begin
      bus(32'h04, 1'b1, {p[2:0], 2'b01});
      tog(0, i1);
      tog(0, i1);
      tog(0, i2);
      chk(i1 + i2, (eA + eB + 2) << p);
      chk(i1 == (eA + 1) << p || i1 == (eB + 1) << p, 1);
    end
    bus(32'h00, 1'b0, 32'h0);
    chk(rd & 32'h18, 32'h18);
    // capture on falling edges, then on rising edges
    bus(32'h04, 1'b1, 32'h02);
    cyc(20);
    bus(32'h00, 1'b1, 32'h00);
    rchk(32'h00, 32'h0);
    pins[0].capA <= 1'b1;
    pins[0].capB <= 1'b1;
    cyc(8);
    rchk(32'h00, 32'h0);
    pins[0].capB <= 1'b0;
    cyc(8);
    rchk(32'h00, 32'h80);
    bus(32'h04, 1'b1, 32'h42);
    pins[0].capA <= 1'b0;
    cyc(8);
    rchk(32'h00, 32'h80);
    pins[0].capA <= 1'b1;
    cyc(8);
    rchk(32'h00, 32'hC0);
    bus(32'h00, 1'b1, 32'hE0);
    cyc(3);
    chk(timerIrq, 2'b01);
    bus(32'h00, 1'b1, 32'h20);
    cyc(3);
    chk(timerIrq, 2'b00);
    rtWrap <= 1'b1;
    @(posedge ref_clk);
    rtWrap <= 1'b0;
    rchk(32'h04, 32'hC2);
    bus(32'h04, 1'b1, 32'h42);
    rchk(32'h04, 32'h42);
    // wrap pulse lands in the data phase of a clearing write: the set must win
    fork
      bus(32'h04, 1'b1, 32'h42);
      begin
        @(posedge ref_clk);
        rtWrap <= 1'b1;
        @(posedge ref_clk);
        rtWrap <= 1'b0;
      end
    join
    rchk(32'h04, 32'hC2);
    bus(32'h24, 1'b1, 32'h80);
    cyc(3);
    chk(portReadSrc, 1'b1);
    rchk(32'h24, 32'h80);
    // event counter: only the selected edge advances, zero compare toggles
    for (int s = 1; s >= 0; s--) begin
      bus(32'h24, 1'b1, {s[0], 5'h03});
      cyc(10);
      repeat (3) begin
        for (int l = 1; l >= 0; l--) begin
          prev = timerOut[1];
          pins[1].extClk <= l[0];
          cyc(8);
          chk(timerOut[1] != prev, l == s);
        end
      end
    end
    chk(portReadSrc, 1'b0);
    // free run: next match only after a full wrap
    bus(32'h00, 1'b1, 32'h04);
    tog(0, i1);
    chk(i1 > 60000, 1);
    cyc(3);
    chk(timerIrq, 2'b01);
    rchk(32'h00, 32'h0E);
    // wrap flag alone holds the request once only its enable is left
    bus(32'h00, 1'b1, 32'h03);
    cyc(3);
    chk(timerIrq, 2'b01);
    bus(32'h00, 1'b1, 32'h02);
    cyc(3);
    chk(timerIrq, 2'b00);
    rchk(32'h00, 32'h02);
    summarize();
  end
  // hang guard, well above the longest expected run
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
